// ### sim/serial_node.sv
/* Remote serial node: sends frames, decodes 8-bit frames.
   Assumes a bit period of BIT clocks of clk_i. */
`timescale 1ns/1ps
`default_nettype none
module serial_node #(
  parameter int BIT = 32
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output var logic  line_o
);
  logic [7:0] last_q;
  int         count_q;
  initial
  begin
    line_o = 1'b1;
    count_q = 0;
    last_q = 8'h00;
  end
  // Caller picks the slot after data, so faults can be injected
  task automatic send(input logic [7:0] b, input logic stop);
    int i;
    @(negedge clk_i);
    line_o = 1'b0;
    repeat (BIT) @(negedge clk_i);
    for (i = 0; i < 8; i++)
    begin
      line_o = b[i];
      repeat (BIT) @(negedge clk_i);
    end
    line_o = stop;
    repeat (BIT) @(negedge clk_i);
    line_o = 1'b1;
    repeat (BIT) @(negedge clk_i);
  endtask
  // Mid-bit sampling, least significant bit first
  always
  begin
    @(negedge line_i);
    repeat (BIT / 2) @(posedge clk_i);
    repeat (8)
    begin
      repeat (BIT) @(posedge clk_i);
      last_q = {line_i, last_q[7:1]};
    end
    repeat (BIT) @(posedge clk_i);
    count_q++;
  end
endmodule // serial_node
`default_nettype wire

// ### sim/uart_irq_status_baud_gen_properties.sv
/* Port checker for the serial port block.
   Assumes the register map header and the bind below. */
`timescale 1ns/1ps
`default_nettype none
`include "uart_map.vh"
module uart_irq_status_baud_gen_properties (
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        serial_in_pin_i,
  input wire logic        serial_out_pin_o,
  input wire logic        cts_n_i,
  input wire logic        tx_irq_o,
  input wire logic        rx_irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  wire wr_data = reg_wr_i && reg_addr_i == `ADDR_DATA;
  wire rd_data = reg_rd_i && reg_addr_i == `ADDR_DATA;
  wire at_stat = reg_addr_i == `ADDR_STAT0;
  AST_HOLD_CLR: assert property (wr_data ##[1:3] at_stat |=> !reg_rdata_o[2])
    else $error("holding flag set after data write");
  AST_TX_IRQ_CLR: assert property (wr_data |-> ##2 !tx_irq_o)
    else $error("transmit irq still high after data write");
  // Start bit spans at least 16 clocks, so 8 is a safe floor
  AST_START_HOLD: assert property ($fell(serial_out_pin_o) && !tx_irq_o |=> !tx_irq_o [*8])
    else $error("holding flag set during start bit");
  AST_CTS: assert property (at_stat |=> reg_rdata_o[0] == $past(cts_n_i))
    else $error("status bit 0 differs from cts level");
  AST_RST_STAT: assert property ($past(srst_i) && at_stat |=> reg_rdata_o[2:1] == 2'b11)
    else $error("status after reset not empty and idle");
  // Pending overrun may reload the available flag
  AST_AVAIL_CLR: assert property (rd_data ##[1:2] at_stat |=> !reg_rdata_o[7] || reg_rdata_o[5])
    else $error("available flag survives data read");
  AST_TX_IRQ_HOLD: assert property (tx_irq_o && !$past(reg_wr_i) && at_stat |=> reg_rdata_o[2])
    else $error("transmit irq without holding empty");
  AST_UNMAPPED: assert property (reg_addr_i[11:3] != 9'h1E8 |=> reg_rdata_o == 8'h00)
    else $error("unmapped address reads nonzero");
endmodule // uart_irq_status_baud_gen_properties
bind uart_irq_status_baud_gen uart_irq_status_baud_gen_properties props_i (
  .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
  .cts_n_i(cts_n_i), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
`default_nettype wire

// ### sim/uart_irq_status_baud_gen_tb.sv
/* Self-checking bench for the serial port block.
   Assumes divisor 2, so one bit is 32 clocks. */
`timescale 1ns/1ps
`default_nettype none
`include "uart_map.vh"
module uart_irq_status_baud_gen_tb;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [11:0] reg_addr_i = `ADDR_STAT0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        cts_n_i = 1'b0;
  wire  [7:0]  reg_rdata_o;
  wire         rxd, txd, tx_irq_o, rx_irq_o;
  int          n_errors = 0;
  int          n_tests = 0;
  initial forever #25 mclk_i = ~mclk_i;
  uart_irq_status_baud_gen uart_irq_status_baud_gen_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .serial_in_pin_i(rxd),
    .serial_out_pin_o(txd), .cts_n_i(cts_n_i), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
  serial_node #(.BIT(32)) serial_node_i (.clk_i(mclk_i), .line_i(txd), .line_o(rxd));
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic wait_irq(input logic tx, output int n);
    for (n = 0; n < 2000 && (tx ? tx_irq_o : rx_irq_o) !== 1'b1; n++)
      @(negedge mclk_i);
  endtask
  task automatic wait_tx(input int c, input logic [7:0] exp);
    int i;
    for (i = 0; i < 2000 && serial_node_i.count_q < c; i++)
      @(negedge mclk_i);
    chk(serial_node_i.last_q, exp);
  endtask
  initial
  begin
    int n;
    repeat (8) @(negedge mclk_i);
    srst_i = 1'b0;
    rd(`ADDR_STAT0, 8'h06);
    rd(12'hF48, 8'h00);
    wr(`ADDR_BAUD_HI, 8'h00);
    wr(`ADDR_BAUD_LO, 8'h02);
    rd(`ADDR_BAUD_LO, 8'h02);
    wr(`ADDR_CTL0, 8'hC0);
    wr(`ADDR_DATA, 8'hA5);
    @(negedge mclk_i);
    chk({7'h00, tx_irq_o}, 8'h00);
    rd(`ADDR_STAT0, 8'h00);
    wait_irq(1'b1, n);
    rd(`ADDR_STAT0, 8'h04);
    wr(`ADDR_DATA, 8'h5A);
    wait_tx(1, 8'hA5);
    wait_tx(2, 8'h5A);
    repeat (40) @(negedge mclk_i);
    rd(`ADDR_STAT0, 8'h06);
    chk({7'h00, tx_irq_o}, 8'h01);
    serial_node_i.send(8'h3C, 1'b1);
    chk({7'h00, rx_irq_o}, 8'h01);
    rd(`ADDR_STAT0, 8'h86);
    rd(`ADDR_DATA, 8'h3C);
    rd(`ADDR_DATA, 8'h3C);
    rd(`ADDR_STAT0, 8'h06);
    serial_node_i.send(8'h11, 1'b1);
    serial_node_i.send(8'h22, 1'b1);
    rd(`ADDR_STAT0, 8'h86);
    rd(`ADDR_DATA, 8'h11);
    rd(`ADDR_STAT0, 8'hA6);
    rd(`ADDR_DATA, 8'h11);
    rd(`ADDR_STAT0, 8'h06);
    serial_node_i.send(8'h5A, 1'b0);
    rd(`ADDR_STAT0, 8'h96);
    rd(`ADDR_DATA, 8'h5A);
    serial_node_i.send(8'h00, 1'b0);
    rd(`ADDR_STAT0, 8'h9E);
    rd(`ADDR_DATA, 8'h00);
    // Disable before reconfiguring; the slot after data acts as parity
    wr(`ADDR_CTL0, 8'h00);
    wr(`ADDR_CTL0, 8'hD0);
    serial_node_i.send(8'h03, 1'b1);
    rd(`ADDR_STAT0, 8'hC6);
    rd(`ADDR_DATA, 8'h03);
    wr(`ADDR_CTL0, 8'h00);
    wr(`ADDR_CTL1, 8'h02);
    wr(`ADDR_CTL0, 8'hC0);
    serial_node_i.send(8'h44, 1'b1);
    chk({7'h00, rx_irq_o}, 8'h00);
    rd(`ADDR_DATA, 8'h44);
    serial_node_i.send(8'h44, 1'b0);
    chk({7'h00, rx_irq_o}, 8'h01);
    rd(`ADDR_DATA, 8'h44);
    wr(`ADDR_CTL0, 8'h00);
    wr(`ADDR_BAUD_LO, 8'h0A);
    wr(`ADDR_CTL1, 8'h05);
    wait_irq(1'b0, n);
    @(negedge mclk_i);
    wait_irq(1'b0, n);
    chk(8'(n + 1), 8'h0A);
    @(negedge mclk_i);
    cts_n_i = 1'b1;
    rd(`ADDR_STAT0, 8'h07);
    report_and_stop();
  end
  initial
  begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
endmodule // uart_irq_status_baud_gen_tb
`default_nettype wire

// ### verilog/baud_counter.v
/*
  Baud divider counter: down-counter reloading from the divisor.
  Assumes divisor stable while the port is enabled.
*/
`timescale 1ns/1ps
`default_nettype none
module baud_counter #(
  parameter WIDTH = 16
) (
  input  wire             mclk_i,
  input  wire             srst_i,
  input  wire [WIDTH-1:0] divisor_i,
  output reg  [WIDTH-1:0] count_o,
  output reg              reload_o
);
  // Divisor of zero is held at one so the tick never stops
  wire [WIDTH-1:0] start_w = (divisor_i == {WIDTH{1'b0}}) ? {{(WIDTH-1){1'b0}}, 1'b1}
                                                           : divisor_i;
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      count_o  <= {{(WIDTH-1){1'b0}}, 1'b1};
      reload_o <= 1'b0;
    end
    else if (count_o <= {{(WIDTH-1){1'b0}}, 1'b1})
    begin
      count_o  <= start_w;
      reload_o <= 1'b1;
    end
    else
    begin
      count_o  <= count_o - {{(WIDTH-1){1'b0}}, 1'b1};
      reload_o <= 1'b0;
    end
  end
endmodule // baud_counter
`default_nettype wire

// ### verilog/uart_irq_status_baud_gen.v
/*
  Serial port: data registers, status flags, interrupts, baud divider,
  simple transmitter and receiver. Assumes a byte register port whose
  read strobe lasts one clock and serial pins synchronous to mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_map.vh"
module uart_irq_status_baud_gen (
  input  wire        mclk_i,
  input  wire        srst_i,
  input  wire [11:0] reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire        serial_in_pin_i,
  output reg         serial_out_pin_o,
  input  wire        cts_n_i,
  output reg         tx_irq_o,
  output reg         rx_irq_o
);
  localparam TX_IDLE = 2'h0;
  localparam TX_SEND = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_RECV = 2'h1;

  // Address compare, shared by the data select and the register write selects
  function sel;
    input [11:0] a;
    input [11:0] b;
    sel = (a == b);
  endfunction

  reg  [7:0]  ctl0_q, ctl1_q, cmp_q, baud_hi_q, baud_lo_q;
  reg  [7:0]  tx_hold_q, rx_byte_q;
  reg         tx_holding_empty_q, tx_shifter_idle_q;
  reg         rx_byte_available_q, parity_fault_q, framing_fault_q, break_seen_q;
  reg         overrun_q, pend_ovr_q, pend_brk_q, mp_rx_q, match_q;
  reg  [1:0]  tx_state_q, rx_state_q;
  reg  [3:0]  tx_sub_q, rx_sub_q;
  reg  [3:0]  tx_bit_q, rx_bit_q;
  reg  [11:0] tx_shift_q;
  reg  [10:0] rx_shift_q;
  reg         rx_evt_q;
  wire [15:0] baud_count_w;
  wire        tick_w;

  wire        dat_sel_w  = sel(reg_addr_i, `ADDR_DATA);
  wire        rd_data_w  = reg_rd_i & dat_sel_w;
  wire        wr_data_w  = reg_wr_i & dat_sel_w;
  wire        nine_w     = ctl1_q[`C1_NINE_BIT];
  wire        par_w      = ctl0_q[`C0_PAR_EN] & ~nine_w;
  wire        extra_w    = par_w | nine_w;
  // Start and stop bits counted, so back-to-back frames keep a full stop
  wire [3:0]  nbits_w    = 4'hA + {3'h0, extra_w} + {3'h0, ctl0_q[`C0_TWO_STOP]};
  wire        rx_line_w  = ctl0_q[`C0_LOOPBACK] ? serial_out_pin_o : serial_in_pin_i;

  baud_counter #(
    .WIDTH(16)
  ) u_baud (
    .mclk_i   (mclk_i),
    .srst_i   (srst_i),
    .divisor_i({baud_hi_q, baud_lo_q}),
    .count_o  (baud_count_w),
    .reload_o (tick_w)
  );

  // Received frame fields, data LSB first after start bit
  wire [7:0] f_data_w  = rx_shift_q[8:1];
  wire       f_extra_w = rx_shift_q[9];
  wire       f_stop_w  = extra_w ? rx_shift_q[10] : rx_shift_q[9];
  wire       f_par_ok_w = ~par_w | ((^f_data_w) ^ f_extra_w ^ ctl0_q[`C0_PAR_ODD]) == 1'b0;
  wire       f_break_w = ~|f_data_w & ~(extra_w & f_extra_w) & ~f_stop_w;
  wire       f_addr_w  = nine_w & f_extra_w;
  wire       f_match_w = (f_data_w == cmp_q);
  // Decide whether a nine-bit frame counts as delivered data
  reg        f_take_w;
  always @*
  begin
    f_take_w = 1'b1;
    if (nine_w)
    begin
      case ({ctl1_q[`C1_MODE_HI], ctl1_q[`C1_MODE_LO]})
        2'h0:    f_take_w = 1'b1;
        2'h1:    f_take_w = f_addr_w;
        2'h2:    f_take_w = f_addr_w ? f_match_w : match_q;
        2'h3:    f_take_w = ~f_addr_w & match_q;
        default: f_take_w = 1'b1;
      endcase
    end
  end

  // Clear-to-send only gates the start of a frame
  wire tx_go_w = ~tx_holding_empty_q & ctl0_q[`C0_TX_EN]
                 & ~(ctl0_q[`C0_CTS_EN] & cts_n_i);

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ctl0_q <= 8'h00;
      ctl1_q <= 8'h00;
      cmp_q <= 8'h00;
      {baud_hi_q, baud_lo_q} <= `BAUD_RESET;
      tx_hold_q <= 8'h00;
      rx_byte_q <= 8'h00;
      tx_holding_empty_q <= 1'b1;
      tx_shifter_idle_q <= 1'b1;
      rx_byte_available_q <= 1'b0;
      parity_fault_q <= 1'b0;
      framing_fault_q <= 1'b0;
      break_seen_q <= 1'b0;
      overrun_q <= 1'b0;
      pend_ovr_q <= 1'b0;
      pend_brk_q <= 1'b0;
      mp_rx_q <= 1'b0;
      match_q <= 1'b0;
      tx_state_q <= TX_IDLE;
      rx_state_q <= RX_IDLE;
      tx_sub_q <= 4'h0;
      rx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
      rx_bit_q <= 4'h0;
      tx_shift_q <= 12'hFFF;
      rx_shift_q <= 11'h000;
      rx_evt_q <= 1'b0;
      serial_out_pin_o <= 1'b1;
      reg_rdata_o <= 8'h00;
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
    end
    else
    begin
      rx_evt_q <= 1'b0;
      // Configuration writes; software keeps them for when the port is off
      if (reg_wr_i & sel(reg_addr_i, `ADDR_CTL0))
        ctl0_q <= reg_wdata_i;
      if (reg_wr_i & sel(reg_addr_i, `ADDR_CTL1))
        ctl1_q <= reg_wdata_i;
      if (reg_wr_i & sel(reg_addr_i, `ADDR_CMP))
        cmp_q <= reg_wdata_i;
      if (reg_wr_i & sel(reg_addr_i, `ADDR_BAUD_HI))
        baud_hi_q <= reg_wdata_i;
      if (reg_wr_i & sel(reg_addr_i, `ADDR_BAUD_LO))
        baud_lo_q <= reg_wdata_i;

      // Data read clears receive flags, loading available, overrun and break from the pending ones; held byte itself is untouched
      if (rd_data_w)
      begin
        rx_byte_available_q <= pend_ovr_q;
        parity_fault_q <= 1'b0;
        framing_fault_q <= 1'b0;
        break_seen_q <= pend_brk_q;
        mp_rx_q <= 1'b0;
        if (!rx_byte_available_q)
          overrun_q <= 1'b0;
        else
          overrun_q <= pend_ovr_q;
        pend_ovr_q <= 1'b0;
        pend_brk_q <= 1'b0;
      end

      // Transmitter
      case (tx_state_q)
        TX_IDLE:
        begin
          if (tx_go_w && tick_w)
          begin
            tx_shift_q <= {1'b1, 1'b1, (nine_w ? ctl1_q[`C1_MP_TX_BIT]
                          : (^tx_hold_q ^ ctl0_q[`C0_PAR_ODD])), tx_hold_q, 1'b0};
            tx_state_q <= TX_SEND;
            tx_sub_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_shifter_idle_q <= 1'b0;
          end
        end
        TX_SEND:
        begin
          if (tick_w)
          begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == 4'hF)
            begin
              if (tx_bit_q == 4'h0)
                tx_holding_empty_q <= 1'b1;
              if (tx_bit_q == 4'h8 && !extra_w)
                tx_shift_q <= {1'b1, tx_shift_q[11:1] | 11'h400} | 12'h001;
              else
                tx_shift_q <= {1'b1, tx_shift_q[11:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == nbits_w - 4'h1)
              begin
                tx_state_q <= TX_IDLE;
                tx_shifter_idle_q <= 1'b1;
              end
            end
          end
        end
        default:
          tx_state_q <= TX_IDLE;
      endcase
      serial_out_pin_o <= ctl0_q[`C0_SEND_BREAK] ? 1'b0
                          : (tx_state_q == TX_SEND) ? tx_shift_q[0] : 1'b1;
      // Load wins over the empty set: the byte just written is unsent
      if (wr_data_w)
      begin
        tx_hold_q <= reg_wdata_i;
        tx_holding_empty_q <= 1'b0;
      end

      // Receiver, samples mid-bit at 16x oversampling
      case (rx_state_q)
        RX_IDLE:
        begin
          if (ctl0_q[`C0_RX_EN] && tick_w && !rx_line_w)
          begin
            rx_state_q <= RX_RECV;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
          end
        end
        RX_RECV:
        begin
          if (tick_w)
          begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == 4'h7)
            begin
              // Short frames have one sample fewer; shift twice to align start
              if (rx_bit_q == 4'h9 && !extra_w)
                rx_shift_q <= {rx_line_w, rx_line_w, rx_shift_q[10:2]};
              else
                rx_shift_q <= {rx_line_w, rx_shift_q[10:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == 4'h0 && rx_line_w)
                rx_state_q <= RX_IDLE;
              else if (rx_bit_q == 4'h9 + {3'h0, extra_w})
              begin
                rx_state_q <= RX_IDLE;
                rx_evt_q <= 1'b1;
              end
            end
          end
        end
        default:
          rx_state_q <= RX_IDLE;
      endcase

      // Frame complete: store the byte or hold back an overrun
      if (rx_evt_q)
      begin
        if (f_addr_w)
          match_q <= f_match_w;
        if (f_take_w)
        begin
          if (rx_byte_available_q && !rd_data_w)
          begin
            overrun_q <= overrun_q;
            pend_ovr_q <= 1'b1;
            pend_brk_q <= f_break_w;
          end
          else
          begin
            rx_byte_q <= f_data_w;
            rx_byte_available_q <= 1'b1;
            parity_fault_q <= ~f_par_ok_w;
            // A break lacks its stop bit too, so framing is flagged as well
            framing_fault_q <= ~f_stop_w;
            break_seen_q <= f_break_w;
            mp_rx_q <= f_extra_w & nine_w;
          end
        end
      end

      // Register read data, registered for one clock
      case (reg_addr_i)
        `ADDR_DATA:    reg_rdata_o <= rx_byte_q;
        `ADDR_STAT0:   reg_rdata_o <= {rx_byte_available_q, parity_fault_q, overrun_q,
                                       framing_fault_q, break_seen_q,
                                       tx_holding_empty_q, tx_shifter_idle_q,
                                       cts_n_i};
        `ADDR_CTL0:    reg_rdata_o <= ctl0_q;
        `ADDR_CTL1:    reg_rdata_o <= ctl1_q;
        `ADDR_STAT1:   reg_rdata_o <= {6'h00, 1'b0, mp_rx_q};
        `ADDR_CMP:     reg_rdata_o <= cmp_q;
        `ADDR_BAUD_HI: reg_rdata_o <= ctl1_q[`C1_COUNT_CTL] ? baud_count_w[15:8]
                                                             : baud_hi_q;
        `ADDR_BAUD_LO: reg_rdata_o <= ctl1_q[`C1_COUNT_CTL] ? baud_count_w[7:0]
                                                             : baud_lo_q;
        default:       reg_rdata_o <= 8'h00;
      endcase

      tx_irq_o <= tx_holding_empty_q & ctl0_q[`C0_TX_EN];
      rx_irq_o <= (rx_byte_available_q & ~ctl1_q[`C1_DATA_IRQ_DIS])
                  | parity_fault_q | framing_fault_q | break_seen_q | overrun_q
                  // Reload interrupt also fires with the port on
                  | (tick_w & ctl1_q[`C1_TIMER_IRQ_EN])
                  | (tick_w & ~ctl0_q[`C0_RX_EN] & ctl1_q[`C1_COUNT_CTL]);
    end
  end
endmodule // uart_irq_status_baud_gen
`default_nettype wire

// ### verilog/uart_map.vh
/*
  Register offsets, status bit positions, control bit positions and reset
  values for the serial port block. Assumes a byte-wide register port
  with 12-bit addresses.
*/
// Functional notes
// - Transmit interrupt raised while the holding-empty flag is set and transmit is enabled.
// - Holding-empty set once the first bit of a character leaves the shifter.
// - Writing transmit data clears the holding-empty flag.
// - Receive interrupt on byte available, break, overrun or framing error.
// - Received-data interrupt has its own disable; errors stay active.
// - Received-data interrupt only after the full character is stored.
// - In nine-bit mode data interrupts depend on address matching; code mode 0 takes every frame, mode 1 every address frame.
// - Overrun keeps the unread byte; new character is dropped.
// - Overrun and break stay hidden until the held byte is read.
// - Receive data changes only on a new complete word, never on read.
// - With baud timer irq enable, receive interrupt on every reload.
// - Divider is 16 bits; bit rate is clock over 16 times divider.
// - With the port disabled the divider acts as a 16-bit timer.
// - Transmit and receive data share address F40H.
// - Status bit 7 byte available; cleared by data read; code keeps it set while an overrun is pending.
// - Status bit 6 parity fault; cleared by data read.
// - Status bit 5 overrun; data read clears it unless another overrun is pending.
// - Status bit 4 framing fault; cleared by data read.
// - Status bit 3 break seen when all frame bits are zero.
// - Status bit 1 shifter idle; bit 0 shows live clear-to-send level.
// - Data irq disable 1 gives errors only; 0 gives data and errors.
// - Receiver off with count control set: irq on each reload, reads show count.
`ifndef UART_MAP_VH
`define UART_MAP_VH
`define ADDR_DATA        12'hF40
`define ADDR_STAT0       12'hF41
`define ADDR_CTL0        12'hF42
`define ADDR_CTL1        12'hF43
`define ADDR_STAT1       12'hF44
`define ADDR_CMP         12'hF45
`define ADDR_BAUD_HI     12'hF46
`define ADDR_BAUD_LO     12'hF47
`define ST_AVAIL         7
`define ST_PARITY        6
`define ST_OVERRUN       5
`define ST_FRAMING       4
`define ST_BREAK         3
`define ST_HOLD_EMPTY    2
`define ST_IDLE          1
`define ST_CTS           0
`define C0_TX_EN         7
`define C0_RX_EN         6
`define C0_CTS_EN        5
`define C0_PAR_EN        4
`define C0_PAR_ODD       3
`define C0_SEND_BREAK    2
`define C0_TWO_STOP      1
`define C0_LOOPBACK      0
`define C1_MODE_HI       7
`define C1_NINE_BIT      6
`define C1_MODE_LO       5
`define C1_MP_TX_BIT     4
`define C1_COUNT_CTL     2
`define C1_DATA_IRQ_DIS  1
`define C1_TIMER_IRQ_EN  0
`define BAUD_RESET       16'h0002
`define OVERSAMPLE       5'h10
`endif
